//--- src/pci_mem_dma.sv
// four channel memory/pci dma engine with wishbone register slave
`include "dma_map.svh"
module pci_mem_dma
   import dma_pkg::*;
(
   input logic clk_i,
   input logic rst_i,
   input logic cyc_i,
   input logic stb_i,
   input logic we_i,
   input logic [7:0] adr_i,
   input logic [3:0] sel_i,
   input logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [31:0] mem_adr_o,
   output logic [31:0] mem_dat_o,
   input logic mem_ack_i,
   input logic [31:0] mem_dat_i,
   output logic pci_req_o,
   output logic pci_we_o,
   output logic pci_mem_space_o,
   output logic [31:0] pci_adr_o,
   output logic [31:0] pci_dat_o,
   input logic pci_ack_i,
   input logic [31:0] pci_dat_i,
   input logic cpu_mem_req_i,
   input logic cpu_mem_we_i,
   input logic cpu_pci_req_i,
   input logic cpu_pci_we_i,
   output logic cpu_bus_ok_strobe_n_o,
   output logic cpu_mem_go_o,
   output logic cpu_pci_go_o,
   input logic irq_en_i,
   output logic [1:0] cmpl_irq_o
);

   // register address decode, used by read and write paths
   function automatic dec_t dec(input logic [7:0] a);
      dec_t d;
      d = '0;
      case (a)
         `CTL_OFS_1: d = '{1'b1, 1'b0, K_CTL, 2'h0};
         `CTL_OFS_2: d = '{1'b1, 1'b0, K_CTL, 2'h1};
         `CTL_OFS_3: d = '{1'b1, 1'b0, K_CTL, 2'h2};
         `CTL_OFS_4: d = '{1'b1, 1'b0, K_CTL, 2'h3};
         `MADR_OFS_1: d = '{1'b1, 1'b0, K_MADR, 2'h0};
         `MADR_OFS_2: d = '{1'b1, 1'b0, K_MADR, 2'h1};
         `MADR_OFS_3: d = '{1'b1, 1'b0, K_MADR, 2'h2};
         `MADR_OFS_4: d = '{1'b1, 1'b0, K_MADR, 2'h3};
         `PADR_OFS_1: d = '{1'b1, 1'b0, K_PADR, 2'h0};
         `PADR_OFS_2: d = '{1'b1, 1'b0, K_PADR, 2'h1};
         `PADR_OFS_3: d = '{1'b1, 1'b0, K_PADR, 2'h2};
         `PADR_OFS_4: d = '{1'b1, 1'b0, K_PADR, 2'h3};
         `NXT_OFS_1: d = '{1'b1, 1'b0, K_NXT, 2'h0};
         `NXT_OFS_2: d = '{1'b1, 1'b0, K_NXT, 2'h1};
         `NXT_OFS_3: d = '{1'b1, 1'b0, K_NXT, 2'h2};
         `NXT_OFS_4: d = '{1'b1, 1'b0, K_NXT, 2'h3};
         `ARB_OFS: d = '{1'b1, 1'b1, K_CTL, 2'h0};
         default: d = '0;
      endcase
      return d;
   endfunction : dec

   // true when address sits on the selected boundary
   function automatic logic bnd_hit(input logic [31:0] a,
                                    input logic [3:0] cd);
      logic [31:0] m;
      m = (32'h1 << (cd + `BND_SHIFT)) - 32'h1;
      return (cd != 4'h0) && ((a & m) == 32'h0);
   endfunction : bnd_hit

   // byte lane merge of a write into an old value
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   st_t st_q, st_d; // engine state and its next value
   dec_t d; // decoded bus address
   logic busy; // a transfer owns the engine
   logic own; // bus access hits the running channel
   logic wr; // bus write taken this cycle
   logic bk; // beat handshake done
   logic mem_ok; // cpu may use memory now
   logic acc_m, acc_p; // cpu transaction accepted
   logic pend; // some channel waits to launch
   logic launch; // load the running copies
   logic [1:0] pick; // lowest pending channel
   logic [31:0] c; // control word of the running channel
   logic [31:0] nv; // merged write value
   logic [31:0] bd; // beat read data
   logic [23:0] c_lo; // running control, non-live fields

   // next state of the whole engine
   always_comb begin
      st_d = st_q;
      d = dec(adr_i);
      busy = (st_q.fsm != S_IDLE);
      own = busy && (st_q.ach == d.ch);
      c = st_q.ctl[st_q.ach];
      c_lo = c[23:0];
      nv = 32'h0;
      launch = 1'b0;
      st_d.mem_go = 1'b0;
      st_d.pci_go = 1'b0;
      st_d.irq = 2'h0;
      // wishbone slave: ack one cycle after the request
      wr = cyc_i && stb_i && we_i && !st_q.ack;
      st_d.ack = cyc_i && stb_i && !st_q.ack;
      st_d.dat = 32'h0;
      // read path, unmapped reads as zero
      if (cyc_i && stb_i && !we_i && !st_q.ack && d.hit) begin
         if (d.arb) begin
            st_d.dat = {18'h0, st_q.arb[13:8], 8'h00};
         end else begin
            unique case (d.kind)
               K_CTL: st_d.dat = {own, st_q.ctl[d.ch][30:0]};
               K_MADR: st_d.dat = st_q.madr[d.ch];
               K_PADR: st_d.dat = st_q.padr[d.ch];
               K_NXT: st_d.dat = st_q.nxt[d.ch];
            endcase
         end
      end
      // write path, unmapped writes dropped
      if (wr && d.hit) begin
         if (d.arb) begin
            nv = merge({18'h0, st_q.arb}, dat_i, sel_i);
            st_d.arb[13:8] = nv[13:8];
         end else begin
            unique case (d.kind)
               K_CTL: begin
                  nv = merge(st_q.ctl[d.ch], dat_i, sel_i);
                  if (own) begin
                     // running: only abort and pause land
                     st_d.ctl[d.ch][`F_ABORT] =
                        st_q.ctl[d.ch][`F_ABORT] | nv[`F_ABORT];
                     st_d.ctl[d.ch][`F_PAUSE] = nv[`F_PAUSE];
                  end else if (nv[`F_ABORT]) begin
                     st_d.ctl[d.ch] = 32'h0;
                  end else begin
                     st_d.ctl[d.ch] = {1'b0, nv[30:0]};
                  end
               end
               K_MADR: if (!own) begin
                  st_d.madr[d.ch] = merge(st_q.madr[d.ch], dat_i, sel_i);
               end
               K_PADR: if (!own) begin
                  st_d.padr[d.ch] = merge(st_q.padr[d.ch], dat_i, sel_i);
               end
               K_NXT: if (!own) begin
                  st_d.nxt[d.ch] = merge(st_q.nxt[d.ch], dat_i, sel_i);
               end
            endcase
         end
      end
      // cpu gating: one accept per strobe, posted writes parked
      mem_ok = !busy || st_q.slot;
      acc_m = 1'b0;
      acc_p = 1'b0;
      if (st_q.ok_n && !st_q.ppend) begin
         if (cpu_pci_req_i && (!busy || cpu_pci_we_i)) begin
            acc_p = 1'b1;
         end else if (cpu_mem_req_i && !st_q.wpend &&
                      (mem_ok || cpu_mem_we_i)) begin
            acc_m = 1'b1;
         end
      end
      st_d.acc_m = acc_m;
      st_d.acc_p = acc_p;
      st_d.ok_n = !(acc_m || acc_p);
      // memory side: direct go or park the write
      if (st_q.wpend && mem_ok) begin
         st_d.mem_go = 1'b1;
         st_d.wpend = 1'b0;
         st_d.slot = 1'b0;
      end else if (acc_m && mem_ok) begin
         st_d.mem_go = 1'b1;
         st_d.slot = 1'b0;
      end else if (acc_m) begin
         st_d.wpend = 1'b1;
      end
      // pci side: writes park until the transfer ends
      if (st_q.ppend && !busy) begin
         st_d.pci_go = 1'b1;
         st_d.ppend = 1'b0;
      end else if (acc_p && !busy) begin
         st_d.pci_go = 1'b1;
      end else if (acc_p) begin
         st_d.ppend = 1'b1;
      end
      // lowest pending channel wins
      pend = 1'b0;
      pick = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (st_q.ctl[i][`F_GO]) begin
            pend = 1'b1;
            pick = 2'(i);
         end
      end
      bk = (st_q.mem_req && mem_ack_i) || (st_q.pci_req && pci_ack_i);
      bd = st_q.mem_req ? mem_dat_i : pci_dat_i;
      // transfer sequencer
      unique case (st_q.fsm)
         S_IDLE: begin
            if (pend) begin
               st_d.ach = pick;
               launch = 1'b1;
            end
         end
         S_SRC: begin
            st_d.mem_adr = st_q.cur_m;
            st_d.pci_adr = st_q.cur_p;
            st_d.pci_sp = c[`F_SPACE];
            if (!st_q.mem_req && !st_q.pci_req) begin
               if (c[`F_ABORT]) begin
                  st_d.fsm = S_DONE;
               end else if (!c[`F_PAUSE]) begin
                  st_d.pci_req = c[`F_DIR];
                  st_d.mem_req = !c[`F_DIR];
                  st_d.mem_we = 1'b0;
                  st_d.pci_we = 1'b0;
               end
            end else if (bk) begin
               // read side done, hand word to write side
               st_d.mem_req = c[`F_DIR];
               st_d.pci_req = !c[`F_DIR];
               st_d.mem_we = 1'b1;
               st_d.pci_we = 1'b1;
               st_d.mem_dat = bd;
               st_d.pci_dat = bd;
               st_d.fsm = S_DST;
            end
         end
         S_DST: begin
            if (bk) begin
               st_d.mem_req = 1'b0;
               st_d.pci_req = 1'b0;
               st_d.cur_m = st_q.cur_m + 32'h4;
               if (c[`F_STEP]) begin
                  st_d.cur_p = st_q.cur_p + 32'h4;
               end
               st_d.words = st_q.words - 19'h1;
               if (bnd_hit(st_q.cur_m + 32'h4, c[23:20])) begin
                  st_d.slot = 1'b1;
               end
               if (c[`F_ABORT]) begin
                  st_d.fsm = S_DONE;
               end else if (st_q.words != 19'h1) begin
                  st_d.fsm = S_SRC;
               end else if (st_q.arb[8 + st_q.ach] &&
                            st_q.nxt[st_q.ach] != 32'h0) begin
                  st_d.fsm = S_FETCH;
                  st_d.idx = 2'h0;
               end else begin
                  st_d.fsm = S_DONE;
               end
            end
         end
         S_FETCH: begin
            st_d.mem_adr = st_q.nxt[st_q.ach] + {28'h0, st_q.idx, 2'h0};
            if (!st_q.mem_req) begin
               if (c[`F_ABORT]) begin
                  st_d.fsm = S_DONE;
               end else begin
                  st_d.mem_req = 1'b1;
                  st_d.mem_we = 1'b0;
               end
            end else if (bk) begin
               // four descriptor words land in order
               st_d.mem_req = 1'b0;
               st_d.idx = st_q.idx + 2'h1;
               unique case (st_q.idx)
                  2'h0: st_d.madr[st_q.ach] = bd;
                  2'h1: st_d.padr[st_q.ach] = bd;
                  2'h2: begin
                     st_d.ctl[st_q.ach] = {2'b00, bd[29:29], 1'b1,
                        bd[27:25], st_d.ctl[st_q.ach][`F_ABORT], bd[23:0]};
                     st_d.ctl[st_q.ach][`F_IE] = bd[`F_IE];
                  end
                  2'h3: st_d.nxt[st_q.ach] = bd;
               endcase
               if (st_q.idx == `LAST_DESC) begin
                  launch = 1'b1;
               end
            end
         end
         S_DONE: begin
            st_d.ctl[st_q.ach][`F_GO] = 1'b0;
            st_d.ctl[st_q.ach][`F_ABORT] = 1'b0;
            st_d.slot = 1'b0;
            st_d.fsm = S_IDLE;
            if (c[`F_IE] && irq_en_i && !c[`F_ABORT]) begin
               st_d.irq[st_q.ach[1]] = 1'b1;
            end
         end
         default: st_d.fsm = S_IDLE;
      endcase
      // load the running copies of a new structure
      if (launch) begin
         st_d.fsm = S_SRC;
         st_d.cur_m = st_d.madr[st_d.ach];
         st_d.cur_p = st_d.padr[st_d.ach];
         if (st_d.ctl[st_d.ach][19:0] == 20'h0) begin
            st_d.words = `MAX_WORDS;
         end else begin
            st_d.words = 19'((21'(st_d.ctl[st_d.ach][19:0]) + 21'h3) >> 2);
         end
      end
   end

   // state register, reset to idle with channel controls zero, arbitration to 0x0009
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
         st_q.fsm <= S_IDLE;
         st_q.arb <= `ARB_RST;
         st_q.ok_n <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register
   assign dat_o = st_q.dat;
   assign ack_o = st_q.ack;
   assign mem_req_o = st_q.mem_req;
   assign mem_we_o = st_q.mem_we;
   assign mem_adr_o = st_q.mem_adr;
   assign mem_dat_o = st_q.mem_dat;
   assign pci_req_o = st_q.pci_req;
   assign pci_we_o = st_q.pci_we;
   assign pci_mem_space_o = st_q.pci_sp;
   assign pci_adr_o = st_q.pci_adr;
   assign pci_dat_o = st_q.pci_dat;
   assign cpu_bus_ok_strobe_n_o = st_q.ok_n;
   assign cpu_mem_go_o = st_q.mem_go;
   assign cpu_pci_go_o = st_q.pci_go;
   assign cmpl_irq_o = st_q.irq;

   // checks on the engine behaviour
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_MEM_GATE: assert property (
      st_q.mem_go |-> $past(mem_ok)) else $error("cpu memory go outside slot");
   AST_WPEND: assert property (
      st_q.wpend && !mem_ok |=> !st_q.acc_m)
      else $error("memory accepted while write parked");
   AST_PCI_RD: assert property (
      st_q.acc_p && $past(busy) |-> $past(cpu_pci_we_i))
      else $error("pci read accepted during transfer");
   AST_PPEND: assert property (
      st_q.ppend |=> !st_q.acc_m && !st_q.acc_p)
      else $error("cpu accepted while pci write parked");
   AST_LOCK: assert property (
      st_q.fsm == S_DST && $past(st_q.fsm) == S_SRC |-> c_lo == $past(c_lo))
      else $error("running control changed");
   AST_BIG: assert property (
      st_q.fsm == S_SRC && $past(st_q.fsm) == S_IDLE && c[19:0] == 20'h0
      |-> st_q.words == `MAX_WORDS) else $error("zero count not 1 MB");
   AST_SLOT: assert property (
      $rose(st_q.slot) |-> bnd_hit(st_q.cur_m, c[23:20]))
      else $error("slot without boundary");
   AST_SPACE: assert property (
      st_q.pci_req |-> st_q.pci_sp == c[`F_SPACE])
      else $error("pci space wrong");
   AST_PAUSE: assert property (
      st_q.fsm == S_SRC && c[`F_PAUSE] && !st_q.mem_req && !st_q.pci_req
      |=> !st_q.mem_req && !st_q.pci_req) else $error("beat while paused");
   AST_DONE: assert property (
      st_q.fsm == S_DONE |=> !c[`F_GO] && !c[`F_ABORT])
      else $error("launch or abort not cleared");
   AST_IRQ: assert property (
      st_q.irq != 2'h0 |-> $past(irq_en_i) && $past(st_q.fsm) == S_DONE)
      else $error("stray completion interrupt");
   AST_ACK: assert property (
      st_q.ack |=> !st_q.ack) else $error("ack longer than one cycle");

endmodule : pci_mem_dma

//--- src/dma_map.svh
// register offsets, field positions, reset values of the dma engine
// Contract
// - cpu memory locked out except boundary slots
// - posted cpu write stalls memory until slot
// - cpu pci read waits for dma end
// - posted pci write stalls all cpu accesses
// - idle channel register sets stay accessible
// - running channel accepts only abort and pause
// - byte count zero means one megabyte
// - boundary match grants one cpu transaction
// - boundary code n selects 16 shl n
// - abort ends transfer, resets channel, self clears; on a running channel only the launch and abort bits clear
// - space bit picks pci memory or io
// - step bit advances pci address
// - pause halts after current cycle, clear resumes
// - launch bit starts, hardware clears at end
// - direction bit picks pci to memory
// - completion interrupt when enabled globally too
// - active bit reads channel busy
// - arbitration register resets 0x0009, low byte reads zero
// - chaining enables bits 8 and 9
// - chaining enables bits 10 and 11
// - chain fetches descriptors until pointer zero
// - descriptor is four contiguous words
`ifndef DMA_MAP_SVH
`define DMA_MAP_SVH
`define CTL_OFS_1 8'h38
`define CTL_OFS_2 8'h44
`define CTL_OFS_3 8'hA4
`define CTL_OFS_4 8'hB0
`define MADR_OFS_1 8'h3C
`define MADR_OFS_2 8'h48
`define MADR_OFS_3 8'hA8
`define MADR_OFS_4 8'hB4
`define PADR_OFS_1 8'h40
`define PADR_OFS_2 8'h4C
`define PADR_OFS_3 8'hAC
`define PADR_OFS_4 8'hB8
`define NXT_OFS_1 8'hBC
`define NXT_OFS_2 8'hC0
`define NXT_OFS_3 8'hC4
`define NXT_OFS_4 8'hC8
`define ARB_OFS 8'h80
`define F_ABORT 24
`define F_SPACE 25
`define F_STEP 26
`define F_PAUSE 27
`define F_GO 28
`define F_DIR 29
`define F_IE 30
`define ARB_RST 14'h0009
`define MAX_WORDS 19'h40000
`define BND_SHIFT 5'h04
`define LAST_DESC 2'h3
`endif

//--- src/dma_pkg.sv
// types of the four channel pci memory dma engine
package dma_pkg;
   // transfer sequencer states, one-hot
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_SRC = 5'h02,
      S_DST = 5'h04,
      S_FETCH = 5'h08,
      S_DONE = 5'h10
   } fsm_t;
   // register kind inside a channel set
   typedef enum logic [1:0] {
      K_CTL = 2'h0,
      K_MADR = 2'h1,
      K_PADR = 2'h2,
      K_NXT = 2'h3
   } kind_t;
   // decoded register address
   typedef struct packed {
      logic hit;
      logic arb;
      kind_t kind;
      logic [1:0] ch;
   } dec_t;
   // whole engine state
   typedef struct packed {
      fsm_t fsm;
      logic [1:0] ach;
      logic [3:0][31:0] ctl;
      logic [3:0][31:0] madr;
      logic [3:0][31:0] padr;
      logic [3:0][31:0] nxt;
      logic [13:0] arb;
      logic [31:0] cur_m;
      logic [31:0] cur_p;
      logic [18:0] words;
      logic [1:0] idx;
      logic slot;
      logic wpend;
      logic ppend;
      logic ok_n;
      logic acc_m;
      logic acc_p;
      logic mem_go;
      logic pci_go;
      logic mem_req;
      logic mem_we;
      logic [31:0] mem_adr;
      logic [31:0] mem_dat;
      logic pci_req;
      logic pci_we;
      logic pci_sp;
      logic [31:0] pci_adr;
      logic [31:0] pci_dat;
      logic ack;
      logic [31:0] dat;
      logic [1:0] irq;
   } st_t;
endpackage : dma_pkg

//--- verif/beat_target.sv
// behavioural one-word-per-request target for the memory or pci side
module beat_target #(
   parameter logic [31:0] BASE = 32'h0000_0000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] lat_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic ack_o,
   output logic [31:0] rdat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem_q [64]; // contiguous word store
   logic [3:0] cnt_q; // wait cycles before answering
   initial begin
      ack_o = 1'b0;
      rdat_o = 32'h0000_0000;
      cnt_q = 4'h0;
      for (int i = 0; i < 64; i++) mem_q[i] = BASE + i;
   end
   // answer after lat_i waits, one pulse per beat
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      if (rst_i) begin
         cnt_q <= 4'h0;
      end else if (req_i && !ack_o && cnt_q >= lat_i) begin
         ack_o <= 1'b1;
         cnt_q <= 4'h0;
         rdat_o <= mem_q[adr_i[7:2]];
         if (we_i) mem_q[adr_i[7:2]] <= dat_i;
      end else if (req_i && !ack_o) begin
         cnt_q <= cnt_q + 4'h1;
      end else begin
         rdat_o <= ~rdat_o; // released: never the last value
      end
   end
endmodule : beat_target

//--- verif/tb_top.sv
// self-checking bench of the four channel dma engine
`include "dma_map.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, skip = 0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'hF, lat = 4'h6;
   logic [31:0] dat_i = 0, dat_o, rdat, mem_adr_o, mem_dat_o, mem_dat_i;
   logic [31:0] pci_adr_o, pci_dat_o, pci_dat_i;
   logic ack_o, mem_req_o, mem_we_o, mem_ack_i, pci_req_o, pci_we_o;
   logic pci_mem_space_o, pci_ack_i, cpu_bus_ok_strobe_n_o;
   logic cpu_mem_go_o, cpu_pci_go_o, irq_en_i = 0;
   logic cpu_mem_req_i = 0, cpu_mem_we_i = 0, cpu_pci_req_i = 0;
   logic cpu_pci_we_i = 0;
   logic [1:0] cmpl_irq_o;
   int failures = 0, compares = 0, beats = 0, mgo = 0, pgo = 0, b, m;
   logic [63:0] rq[$]; // read notes: mask, value
   logic [64:0] dq[$]; // destination beats: space, address, data
   logic [1:0] iq[$]; // interrupt pulses
   logic [7:0] cofs [4] = '{`CTL_OFS_1, `CTL_OFS_2, `CTL_OFS_3, `CTL_OFS_4};
   logic [7:0] mofs [4] = '{`MADR_OFS_1, `MADR_OFS_2, `MADR_OFS_3,
      `MADR_OFS_4};
   logic [7:0] pofs [4] = '{`PADR_OFS_1, `PADR_OFS_2, `PADR_OFS_3,
      `PADR_OFS_4};
   always #2.5 clk_i = ~clk_i;
   pci_mem_dma dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mem_req_o(mem_req_o),
      .mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o), .mem_dat_o(mem_dat_o),
      .mem_ack_i(mem_ack_i), .mem_dat_i(mem_dat_i), .pci_req_o(pci_req_o),
      .pci_we_o(pci_we_o), .pci_mem_space_o(pci_mem_space_o),
      .pci_adr_o(pci_adr_o), .pci_dat_o(pci_dat_o), .pci_ack_i(pci_ack_i),
      .pci_dat_i(pci_dat_i), .cpu_mem_req_i(cpu_mem_req_i),
      .cpu_mem_we_i(cpu_mem_we_i), .cpu_pci_req_i(cpu_pci_req_i),
      .cpu_pci_we_i(cpu_pci_we_i),
      .cpu_bus_ok_strobe_n_o(cpu_bus_ok_strobe_n_o),
      .cpu_mem_go_o(cpu_mem_go_o), .cpu_pci_go_o(cpu_pci_go_o),
      .irq_en_i(irq_en_i), .cmpl_irq_o(cmpl_irq_o));
   beat_target #(.BASE(32'hC0DE_0000)) u_mem (.clk_i(clk_i), .rst_i(rst_i),
      .lat_i(lat), .req_i(mem_req_o), .we_i(mem_we_o), .adr_i(mem_adr_o),
      .dat_i(mem_dat_o), .ack_o(mem_ack_i), .rdat_o(mem_dat_i));
   beat_target #(.BASE(32'h9E00_0000)) u_pci (.clk_i(clk_i), .rst_i(rst_i),
      .lat_i(lat), .req_i(pci_req_o), .we_i(pci_we_o), .adr_i(pci_adr_o),
      .dat_i(pci_dat_o), .ack_o(pci_ack_i), .rdat_o(pci_dat_i));
   // single comparison point
   task automatic chk(input string nm, input logic [64:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // verdict and end of run
   task automatic test_done();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   // watches outputs and takes the oldest note for each result
   always @(negedge clk_i) begin
      logic [63:0] r;
      if (ack_o && !we_i) begin
         if (rq.size() == 0) chk("read order", 1, 0);
         else begin
            r = rq.pop_front();
            chk("read data", 65'(dat_o & r[63:32]), 65'(r[31:0]));
         end
      end
      if (mem_ack_i || pci_ack_i) beats++;
      if (!skip && ((mem_ack_i && mem_we_o) || (pci_ack_i && pci_we_o))) begin
         if (dq.size() == 0) chk("beat order", 1, 0);
         else chk("dest beat", {pci_ack_i & pci_mem_space_o, pci_ack_i ?
            {pci_adr_o, pci_dat_o} : {mem_adr_o, mem_dat_o}}, dq.pop_front());
      end
      if (cmpl_irq_o !== 2'b00) chk("irq", 65'(cmpl_irq_o),
         65'(iq.size() ? iq.pop_front() : 2'b00));
      if (cpu_mem_go_o) mgo++;
      if (cpu_pci_go_o) pgo++;
   end
   // cpu side drops its request once let through
   always @(posedge clk_i) begin
      if (cpu_mem_go_o) cpu_mem_req_i <= 1'b0;
      if (cpu_pci_go_o) cpu_pci_req_i <= 1'b0;
   end
   // classic wishbone single cycle, waits for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
      if (n >= 50) chk("bus answer", 1, 0);
      rdat = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
      rq.push_back({m, e & m});
      wb(1'b0, a, 32'h0);
   endtask : rd
   // polls the active bit until clear
   task automatic idle(input int c);
      for (int i = 0; i < 400; i++) begin
         rq.push_back(64'h0);
         wb(1'b0, cofs[c], 32'h0);
         if (rdat[31] === 1'b0) break;
      end
      chk("active clear", 65'(rdat[31]), 65'(0));
   endtask : idle
   // one programmed transfer with checks while running and after
   task automatic xfer(input int c, input logic [31:0] ctl,
      input logic [7:0] ma, pa, input int n, input logic g,
      input logic [1:0] irq);
      logic [31:0] v;
      irq_en_i <= g;
      wb(1'b1, mofs[c], 32'(ma));
      wb(1'b1, pofs[c], 32'(pa));
      for (int k = 0; k < n; k++) begin
         if (ctl[29]) dq.push_back({1'b0, 24'h0, ma + 8'(4 * k),
            32'h9E00_0000 + pa[7:2] + (ctl[26] ? k : 0)});
         else dq.push_back({ctl[25], 24'h0, pa + (ctl[26] ? 8'(4 * k) :
            8'h00), 32'hC0DE_0000 + ma[7:2] + k});
      end
      if (irq != 2'b00) iq.push_back(irq);
      wb(1'b1, cofs[c], ctl | 32'h1000_0000);
      rd(cofs[c], ctl | 32'h9000_0000, '1);
      wb(1'b1, cofs[c], ctl ^ 32'h26FF_FFFF);
      rd(cofs[c], ctl | 32'h9000_0000, '1);
      v = $urandom();
      wb(1'b1, mofs[(c + 1) % 4], v);
      rd(mofs[(c + 1) % 4], v, '1);
      idle(c);
      rd(cofs[c], ctl, '1);
      chk("beats left", 65'(dq.size()), 65'(0));
   endtask : xfer
   initial begin
      void'($urandom(32'h6AEE_C944));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) rd(cofs[i], 32'h0, '1);
      rd(`ARB_OFS, 32'h0, '1);
      rd(8'h00, 32'h0, '1);
      wb(1'b1, `ARB_OFS, 32'hFFFF_FFFF);
      rd(`ARB_OFS, 32'h0000_3F00, '1);
      wb(1'b1, `ARB_OFS, 32'h0);
      xfer(0, 32'h4600_0008, 8'h10, 8'h80, 2, 1, 2'b01);
      xfer(1, 32'h2000_0006, 8'h40, 8'hA0, 2, 1, 2'b00);
      xfer(2, 32'h4000_000C, 8'h60, 8'h20, 3, 0, 2'b00);
      xfer(3, 32'h6400_0010, 8'h00, 8'h30, 4, 1, 2'b10);
      // chained run: one word from the registers, one from a descriptor
      u_mem.mem_q[56] <= 32'h0000_0074;
      u_mem.mem_q[57] <= 32'h0000_00C4;
      u_mem.mem_q[58] <= 32'h4400_0004;
      u_mem.mem_q[59] <= 32'h0000_0000;
      wb(1'b1, `NXT_OFS_1, 32'h0000_00E0);
      wb(1'b1, `ARB_OFS, 32'h0000_0100);
      xfer(0, 32'h4400_0004, 8'h70, 8'hC0, 2, 1, 2'b01);
      // long transfer: slots, held pci read, pause, abort
      lat <= 4'h1;
      skip <= 1'b1;
      wb(1'b1, mofs[3], 32'h0);
      wb(1'b1, cofs[3], 32'h1010_0000);
      cpu_mem_req_i <= 1'b1;
      cpu_pci_req_i <= 1'b1;
      repeat (300) @(posedge clk_i);
      chk("mem slot grant", 65'(mgo), 65'(1));
      chk("pci read held", 65'(pgo), 65'(0));
      // cpu memory writes: one into the slot, the next one parked
      b = mgo;
      cpu_mem_we_i <= 1'b1;
      repeat (2) begin
         cpu_mem_req_i <= 1'b1;
         do @(posedge clk_i); while (cpu_bus_ok_strobe_n_o);
         cpu_mem_req_i <= 1'b0;
         @(posedge clk_i);
      end
      cpu_mem_we_i <= 1'b0;
      repeat (120) @(posedge clk_i);
      chk("posted writes", 65'(mgo - b), 65'(2));
      wb(1'b1, cofs[3], 32'h0800_0000);
      repeat (20) @(posedge clk_i);
      b = beats;
      repeat (60) @(posedge clk_i);
      chk("paused beats", 65'(beats - b), 65'(0));
      rd(cofs[3], 32'h9810_0000, '1);
      wb(1'b1, cofs[3], 32'h0);
      b = beats;
      repeat (60) @(posedge clk_i);
      chk("resumed", 65'(beats != b), 65'(1));
      wb(1'b1, cofs[3], 32'h0100_0000);
      idle(3);
      rd(cofs[3], 32'h0, 32'h9100_0000);
      repeat (20) @(posedge clk_i);
      chk("pci read after end", 65'(pgo), 65'(1));
      // posted pci write holds every cpu access until the end
      wb(1'b1, cofs[2], 32'h1000_0000);
      b = pgo;
      m = mgo;
      cpu_pci_we_i <= 1'b1;
      cpu_pci_req_i <= 1'b1;
      do @(posedge clk_i); while (cpu_bus_ok_strobe_n_o);
      cpu_pci_req_i <= 1'b0;
      cpu_mem_req_i <= 1'b1;
      repeat (100) @(posedge clk_i);
      chk("pci write parked", 65'(pgo - b), 65'(0));
      chk("cpu held", 65'(mgo - m), 65'(0));
      wb(1'b1, cofs[2], 32'h0100_0000);
      idle(2);
      repeat (20) @(posedge clk_i);
      chk("pci write after end", 65'(pgo - b), 65'(1));
      chk("cpu after end", 65'(mgo - m), 65'(1));
      chk("notes left", 65'(rq.size() + iq.size()), 65'(0));
      test_done();
   end
   // cuts a hang short
   initial begin
      #300000;
      failures++;
      test_done();
   end
endmodule : tb_top
